//--- src/cmd_decode_pkg.sv
// Package: command encodings, bank states, timing counts for the command decoder.
// Assumes a single 25 MHz command clock.
package cmd_decode_pkg;
  localparam int unsigned CLK_PERIOD_NS = 40;
  localparam int unsigned NUM_BANKS = 8;
  localparam int unsigned BANK_W = 3;
  localparam int unsigned ADDR_W = 14;
  localparam int unsigned AP_BIT = 10;
  localparam int unsigned BURST_LEN = 4;
  // Timing figures in ns except tMRD in clocks, counts rounded up to whole cycles
  localparam int unsigned T_RP_NS = 15;
  localparam int unsigned T_RCD_NS = 15;
  localparam int unsigned T_WR_NS = 15;
  localparam int unsigned T_RFC_NS = 128;
  localparam int unsigned T_MRD_CK = 2;
  localparam int unsigned T_XSNR_NS = 138;
  localparam int unsigned CNT_W = 4;
  localparam logic [CNT_W-1:0] RP_CYC = CNT_W'((T_RP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [CNT_W-1:0] RCD_CYC = CNT_W'((T_RCD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [CNT_W-1:0] WR_CYC = CNT_W'((T_WR_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [CNT_W-1:0] RFC_CYC = CNT_W'((T_RFC_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [CNT_W-1:0] MRD_CYC = CNT_W'(T_MRD_CK);
  localparam logic [CNT_W-1:0] XSNR_CYC = CNT_W'((T_XSNR_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [CNT_W-1:0] BURST_CYC = CNT_W'(BURST_LEN / 2);

  typedef enum logic [8:0] {
    CMD_DESEL = 9'h001,
    CMD_NOP = 9'h002,
    CMD_MODE = 9'h004,
    CMD_REFRESH = 9'h008,
    CMD_PRE = 9'h010,
    CMD_ACT = 9'h020,
    CMD_WRITE = 9'h040,
    CMD_READ = 9'h080,
    CMD_BAD = 9'h100
  } cmd_t;

  typedef enum logic [7:0] {
    BK_IDLE = 8'h01,
    BK_ACTIVATING = 8'h02,
    BK_ACTIVE = 8'h04,
    BK_READ = 8'h08,
    BK_WRITE = 8'h10,
    BK_READ_AP = 8'h20,
    BK_WRITE_AP = 8'h40,
    BK_PRECHARGING = 8'h80
  } bank_state_t;

  typedef enum logic [3:0] {
    PWR_ON = 4'h1,
    PWR_DOWN = 4'h2,
    PWR_SELF = 4'h4,
    PWR_XSNR = 4'h8
  } pwr_state_t;
endpackage : cmd_decode_pkg

//--- src/cmd_decoder.sv
// Combinational decode of the strobe levels into one command.
// Assumes strobes are synchronous to clk_i and sampled by the caller.
`timescale 1ns/1ps
`default_nettype none
module cmd_decoder (
  // Strobes, active low
  input wire logic cs_n_i,
  input wire logic ras_n_i,
  input wire logic cas_n_i,
  input wire logic we_n_i,
  // Decoded command
  output cmd_decode_pkg::cmd_t cmd_o
);
  wire [3:0] strobes = {cs_n_i, ras_n_i, cas_n_i, we_n_i};

  always_comb
  begin
    cmd_o = cmd_decode_pkg::CMD_BAD;
    if (cs_n_i)
      cmd_o = cmd_decode_pkg::CMD_DESEL;
    else
      unique case (strobes[2:0])
        3'h7: cmd_o = cmd_decode_pkg::CMD_NOP;
        3'h0: cmd_o = cmd_decode_pkg::CMD_MODE;
        3'h1: cmd_o = cmd_decode_pkg::CMD_REFRESH;
        3'h2: cmd_o = cmd_decode_pkg::CMD_PRE;
        3'h3: cmd_o = cmd_decode_pkg::CMD_ACT;
        3'h4: cmd_o = cmd_decode_pkg::CMD_WRITE;
        3'h5: cmd_o = cmd_decode_pkg::CMD_READ;
        default: cmd_o = cmd_decode_pkg::CMD_BAD;
      endcase
  end
endmodule : cmd_decoder
`default_nettype wire

//--- src/bank_fsm.sv
// One bank's state machine with its timing counter.
// Assumes the top qualifies commands for this bank and clock enable.
`timescale 1ns/1ps
`default_nettype none
module bank_fsm (
  // Clock and reset
  input wire logic clk_i,
  input wire logic sys_rst_i,
  // Command aimed at this bank, already qualified
  input wire logic act_i,
  input wire logic rd_i,
  input wire logic wr_i,
  input wire logic pre_i,
  input wire logic ap_i,
  input wire logic bad_i,
  // State
  output cmd_decode_pkg::bank_state_t state_o,
  output logic illegal_o
);
  cmd_decode_pkg::bank_state_t state_ff, nxt_state;
  logic [cmd_decode_pkg::CNT_W-1:0] cnt_ff, nxt_cnt;
  logic illegal_ff, nxt_illegal;
  wire cnt_done = (cnt_ff == '0);
  wire any_cmd = act_i | rd_i | wr_i | pre_i | bad_i;
  wire col_cmd = rd_i | wr_i;
  wire [cmd_decode_pkg::CNT_W-1:0] cnt_dec = cnt_done ? cnt_ff : cnt_ff - 1'b1;

  // Burst plus precharge time, plus write recovery for writes, for auto precharge
  function automatic logic [cmd_decode_pkg::CNT_W-1:0] ap_len(input logic is_wr);
    ap_len = cmd_decode_pkg::BURST_CYC + cmd_decode_pkg::RP_CYC + (is_wr ? cmd_decode_pkg::WR_CYC : '0);
  endfunction : ap_len

  always_comb
  begin
    nxt_state = state_ff;
    nxt_cnt = cnt_dec;
    nxt_illegal = 1'b0;
    unique case (state_ff)
      cmd_decode_pkg::BK_IDLE:
        if (act_i)
        begin
          nxt_state = cmd_decode_pkg::BK_ACTIVATING;
          nxt_cnt = cmd_decode_pkg::RCD_CYC - 1'b1;
        end
        else if (any_cmd & ~pre_i)
          nxt_illegal = 1'b1;
      cmd_decode_pkg::BK_ACTIVATING, cmd_decode_pkg::BK_PRECHARGING,
      cmd_decode_pkg::BK_READ_AP, cmd_decode_pkg::BK_WRITE_AP:
      begin
        if (any_cmd)
          nxt_illegal = 1'b1;
        if (cnt_done)
          nxt_state = (state_ff == cmd_decode_pkg::BK_ACTIVATING) ? cmd_decode_pkg::BK_ACTIVE
                                                                 : cmd_decode_pkg::BK_IDLE;
      end
      cmd_decode_pkg::BK_ACTIVE, cmd_decode_pkg::BK_READ, cmd_decode_pkg::BK_WRITE:
      begin
        if (state_ff != cmd_decode_pkg::BK_ACTIVE && cnt_done)
          nxt_state = cmd_decode_pkg::BK_ACTIVE;
        if (col_cmd & ap_i)
        begin
          nxt_state = wr_i ? cmd_decode_pkg::BK_WRITE_AP : cmd_decode_pkg::BK_READ_AP;
          nxt_cnt = ap_len(wr_i) - 1'b1;
        end
        else if (col_cmd)
        begin
          nxt_state = wr_i ? cmd_decode_pkg::BK_WRITE : cmd_decode_pkg::BK_READ;
          nxt_cnt = cmd_decode_pkg::BURST_CYC - 1'b1;
        end
        else if (pre_i)
        begin
          nxt_state = cmd_decode_pkg::BK_PRECHARGING;
          nxt_cnt = cmd_decode_pkg::RP_CYC - 1'b1;
        end
        else if (act_i | bad_i)
          nxt_illegal = 1'b1;
      end
      default:
      begin
        nxt_state = cmd_decode_pkg::BK_IDLE;
        nxt_illegal = 1'b1;
      end
    endcase
  end

  always_ff @(posedge clk_i)
  begin
    if (sys_rst_i)
    begin
      state_ff <= cmd_decode_pkg::BK_IDLE;
      cnt_ff <= '0;
      illegal_ff <= 1'b0;
    end
    else
    begin
      state_ff <= nxt_state;
      cnt_ff <= nxt_cnt;
      illegal_ff <= nxt_illegal;
    end
  end

  assign state_o = state_ff;
  assign illegal_o = illegal_ff;
endmodule : bank_fsm
`default_nettype wire

//--- src/sdram_command_decode_bank_fsm.sv
// Top: command decode, clock-enable power states and eight bank machines.
// Assumes the controller drives every command input to a defined level each edge.
`timescale 1ns/1ps
`default_nettype none
// Operation
// - Commands decoded from strobes at rising edge
// - Deselect and no-op continue current operation
// - Bank address selects one of eight banks
// - All strobes low loads mode register
// - Precharge closes one bank or all
// - Read and write carry column, auto precharge
// - Activate opens row in idle bank
// - Self refresh entry by clock enable fall
// - Power-down entered and left with clock enable
// - Four-beat bursts cut short by a new read, write or precharge
// - Termination ignored; unavailable in self refresh
// - Bank legality only with clock enable steady
// - Idle bank takes activate, refresh, mode load
// - Row active takes read, write, precharge
// - Read or write state until burst ends
// - Read burst accepts read, write, precharge
// - Write burst accepts read, write, precharge
// - Precharging lasts precharge period, then idle
// - Activating lasts activate delay, then active
// - Read auto precharge busy until period ends
// - Write auto precharge busy until period ends
module sdram_command_decode_bank_fsm (
  // Clock and reset
  input wire logic clk_i,
  input wire logic sys_rst_i,
  // Command bus, strobes active low
  input wire logic cke_i,
  input wire logic cs_n_i,
  input wire logic ras_n_i,
  input wire logic cas_n_i,
  input wire logic we_n_i,
  input wire logic [cmd_decode_pkg::BANK_W-1:0] ba_i,
  input wire logic [cmd_decode_pkg::ADDR_W-1:0] addr_i,
  input wire logic odt_i,
  // Decoded outputs
  output logic mode_load_o,
  output logic [cmd_decode_pkg::BANK_W-1:0] mode_sel_o,
  output logic [cmd_decode_pkg::ADDR_W-1:0] mode_data_o,
  output logic [cmd_decode_pkg::ADDR_W-1:0] row_o,
  output logic [cmd_decode_pkg::ADDR_W-1:0] col_o,
  output logic refresh_o,
  // Status
  output logic [cmd_decode_pkg::NUM_BANKS-1:0] bank_idle_o,
  output logic [cmd_decode_pkg::NUM_BANKS-1:0] bank_open_o,
  output logic power_down_o,
  output logic self_refresh_o,
  output logic odt_enable_o,
  output logic illegal_o
);
  localparam int unsigned NB = cmd_decode_pkg::NUM_BANKS;

  cmd_decode_pkg::cmd_t cmd;
  cmd_decode_pkg::pwr_state_t pwr_ff, nxt_pwr;
  cmd_decode_pkg::bank_state_t bank_state [NB];
  logic cke_prev_ff;
  logic [cmd_decode_pkg::CNT_W-1:0] gcnt_ff, nxt_gcnt;
  logic glob_busy_ff, nxt_glob_busy;
  logic mode_load_ff, refresh_ff, illegal_ff, nxt_illegal;
  logic [cmd_decode_pkg::BANK_W-1:0] mode_sel_ff;
  logic [cmd_decode_pkg::ADDR_W-1:0] mode_data_ff, row_ff, col_ff;
  logic [NB-1:0] bank_ill;

  cmd_decoder u_dec (
    .cs_n_i(cs_n_i),
    .ras_n_i(ras_n_i),
    .cas_n_i(cas_n_i),
    .we_n_i(we_n_i),
    .cmd_o(cmd)
  );

  // Termination input plays no part in decode
  wire idle_cmd = (cmd == cmd_decode_pkg::CMD_DESEL) || (cmd == cmd_decode_pkg::CMD_NOP);
  wire cke_steady = cke_prev_ff & cke_i;
  wire run = cke_steady && (pwr_ff == cmd_decode_pkg::PWR_ON) && !glob_busy_ff;
  wire ap = addr_i[cmd_decode_pkg::AP_BIT];
  wire [NB-1:0] ba_hot = NB'(1) << ba_i;
  wire [NB-1:0] sel = run ? ba_hot : '0;
  wire do_act = run && cmd == cmd_decode_pkg::CMD_ACT;
  wire do_rd = run && cmd == cmd_decode_pkg::CMD_READ;
  wire do_wr = run && cmd == cmd_decode_pkg::CMD_WRITE;
  wire do_pre = run && cmd == cmd_decode_pkg::CMD_PRE;
  wire do_bad = run && cmd == cmd_decode_pkg::CMD_BAD;
  wire [NB-1:0] pre_mask = ap ? {NB{run}} : sel;
  wire all_idle = &bank_idle_o;
  wire do_mode = run && cmd == cmd_decode_pkg::CMD_MODE && all_idle;
  wire do_ref = run && cmd == cmd_decode_pkg::CMD_REFRESH && all_idle;
  wire sr_entry = cke_prev_ff && !cke_i && cmd == cmd_decode_pkg::CMD_REFRESH
                  && pwr_ff == cmd_decode_pkg::PWR_ON && !glob_busy_ff && all_idle;
  wire pd_entry = cke_prev_ff && !cke_i && idle_cmd && pwr_ff == cmd_decode_pkg::PWR_ON;
  wire glob_bad = run && ((cmd == cmd_decode_pkg::CMD_MODE || cmd == cmd_decode_pkg::CMD_REFRESH) && !all_idle);
  // Commands during a global busy period are ignored but flagged
  wire busy_bad = cke_steady && glob_busy_ff && !idle_cmd;
  // Refused commands must not overwrite the captured fields
  wire act_ok = bank_idle_o[ba_i];
  wire col_ok = bank_open_o[ba_i];

  genvar g;
  generate
    for (g = 0; g < NB; g++)
    begin : g_bank
      bank_fsm u_bank (
        .clk_i(clk_i),
        .sys_rst_i(sys_rst_i),
        .act_i(do_act & sel[g]),
        .rd_i(do_rd & sel[g]),
        .wr_i(do_wr & sel[g]),
        .pre_i(do_pre & pre_mask[g] & (ap ? bank_state[g] != cmd_decode_pkg::BK_IDLE : 1'b1)),
        .ap_i(ap),
        .bad_i(do_bad & sel[g]),
        .state_o(bank_state[g]),
        .illegal_o(bank_ill[g])
      );
      assign bank_idle_o[g] = (bank_state[g] == cmd_decode_pkg::BK_IDLE);
      assign bank_open_o[g] = (bank_state[g] == cmd_decode_pkg::BK_ACTIVE) ||
                              (bank_state[g] == cmd_decode_pkg::BK_READ) ||
                              (bank_state[g] == cmd_decode_pkg::BK_WRITE);
    end
  endgenerate

  // Power and global-busy sequencing
  always_comb
  begin
    nxt_pwr = pwr_ff;
    nxt_gcnt = (gcnt_ff == '0) ? gcnt_ff : gcnt_ff - 1'b1;
    nxt_glob_busy = glob_busy_ff && (gcnt_ff != '0);
    nxt_illegal = glob_bad | busy_bad | do_bad;
    unique case (pwr_ff)
      cmd_decode_pkg::PWR_ON:
        if (sr_entry)
          nxt_pwr = cmd_decode_pkg::PWR_SELF;
        else if (pd_entry)
          nxt_pwr = cmd_decode_pkg::PWR_DOWN;
        else if (do_mode)
        begin
          nxt_glob_busy = 1'b1;
          nxt_gcnt = cmd_decode_pkg::MRD_CYC - 1'b1;
        end
        else if (do_ref)
        begin
          nxt_glob_busy = 1'b1;
          nxt_gcnt = cmd_decode_pkg::RFC_CYC - 1'b1;
        end
      cmd_decode_pkg::PWR_DOWN:
        if (cke_i)
          nxt_pwr = cmd_decode_pkg::PWR_ON;
      cmd_decode_pkg::PWR_SELF:
        // Exit sampled here on the command clock; async exit needs no extra edges
        if (cke_i && idle_cmd)
        begin
          nxt_pwr = cmd_decode_pkg::PWR_XSNR;
          nxt_gcnt = cmd_decode_pkg::XSNR_CYC - 1'b1;
        end
      cmd_decode_pkg::PWR_XSNR:
      begin
        if (!idle_cmd)
          nxt_illegal = 1'b1;
        if (gcnt_ff == '0)
          nxt_pwr = cmd_decode_pkg::PWR_ON;
      end
      default: nxt_pwr = cmd_decode_pkg::PWR_ON;
    endcase
  end

  always_ff @(posedge clk_i)
  begin
    if (sys_rst_i)
    begin
      pwr_ff <= cmd_decode_pkg::PWR_ON;
      cke_prev_ff <= 1'b0;
      gcnt_ff <= '0;
      glob_busy_ff <= 1'b0;
      illegal_ff <= 1'b0;
    end
    else
    begin
      pwr_ff <= nxt_pwr;
      cke_prev_ff <= cke_i;
      gcnt_ff <= nxt_gcnt;
      glob_busy_ff <= nxt_glob_busy;
      illegal_ff <= nxt_illegal;
    end
  end

  // Captured command fields
  always_ff @(posedge clk_i)
  begin
    if (sys_rst_i)
    begin
      mode_load_ff <= 1'b0;
      refresh_ff <= 1'b0;
      mode_sel_ff <= '0;
      mode_data_ff <= '0;
      row_ff <= '0;
      col_ff <= '0;
    end
    else
    begin
      mode_load_ff <= do_mode;
      refresh_ff <= do_ref;
      if (do_mode)
      begin
        mode_sel_ff <= ba_i;
        mode_data_ff <= addr_i;
      end
      if (do_act && act_ok)
        row_ff <= addr_i;
      if ((do_rd | do_wr) && col_ok)
        col_ff <= addr_i & ~(cmd_decode_pkg::ADDR_W'(1) << cmd_decode_pkg::AP_BIT);
    end
  end

  assign mode_load_o = mode_load_ff;
  assign refresh_o = refresh_ff;
  assign mode_sel_o = mode_sel_ff;
  assign mode_data_o = mode_data_ff;
  assign row_o = row_ff;
  assign col_o = col_ff;
  assign power_down_o = (pwr_ff == cmd_decode_pkg::PWR_DOWN);
  assign self_refresh_o = (pwr_ff == cmd_decode_pkg::PWR_SELF);
  assign odt_enable_o = odt_i && (pwr_ff != cmd_decode_pkg::PWR_SELF);
  assign illegal_o = illegal_ff | (|bank_ill);
endmodule : sdram_command_decode_bank_fsm
`default_nettype wire

//--- tb/sdram_cmd_properties.sv
// Checker: port-level timing of the command decoder and its bank machines.
// Assumes one clock domain with synchronous reset; bound to the top below.
`timescale 1ns/1ps
`default_nettype none
module sdram_cmd_properties (
  // Clock, reset, command bus
  input wire logic clk_i,
  input wire logic sys_rst_i,
  input wire logic cke_i,
  input wire logic cs_n_i,
  input wire logic ras_n_i,
  input wire logic cas_n_i,
  input wire logic we_n_i,
  input wire logic [2:0] ba_i,
  input wire logic [13:0] addr_i,
  input wire logic odt_i,
  // Outputs under watch
  input wire logic mode_load_o,
  input wire logic [2:0] mode_sel_o,
  input wire logic [13:0] mode_data_o,
  input wire logic refresh_o,
  input wire logic [7:0] bank_idle_o,
  input wire logic [7:0] bank_open_o,
  input wire logic power_down_o,
  input wire logic self_refresh_o,
  input wire logic odt_enable_o,
  input wire logic illegal_o
);
  wire logic ras_w = !cs_n_i && !ras_n_i;
  wire logic act_w = ras_w && cas_n_i && we_n_i;
  wire logic pre_w = ras_w && cas_n_i && !we_n_i;
  wire logic ref_w = ras_w && !cas_n_i && we_n_i;
  wire logic mode_w = ras_w && !cas_n_i && !we_n_i;

  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (sys_rst_i);

  a_mode_cause: assert property (mode_load_o |-> $past(mode_w && cke_i) && $past(cke_i, 2))
    else $error("mode load pulse without a mode load command");
  a_mode_fields: assert property (mode_load_o |-> mode_sel_o == $past(ba_i) && mode_data_o == $past(addr_i))
    else $error("mode fields differ from the sampled bus");
  a_refresh_cause: assert property (refresh_o |-> $past(ref_w && cke_i && (&bank_idle_o)) && $past(cke_i, 2))
    else $error("refresh pulse without refresh to idle banks");
  a_odt_gate: assert property (odt_enable_o == (odt_i && !self_refresh_o))
    else $error("termination enable wrong");
  a_idle_open: assert property ((bank_idle_o & bank_open_o) == 8'h00)
    else $error("bank both idle and open");
  a_open_after_act: assert property (|(bank_open_o & ~$past(bank_open_o)) |-> $past(act_w && cke_i, 2))
    else $error("bank opened without activate");
  a_leave_idle: assert property (|($past(bank_idle_o) & ~bank_idle_o) |-> $past(act_w && cke_i))
    else $error("bank left idle without activate");
  a_pre_closes: assert property (pre_w && !addr_i[10] && ba_i == 3'h5 && bank_open_o[5]
    && cke_i && $past(cke_i) |-> ##[1:3] bank_idle_o[5])
    else $error("precharge did not close the bank");
  a_illegal_cause: assert property (illegal_o |-> $past(!cs_n_i) || $past(!cs_n_i, 2))
    else $error("illegal flag after a deselect");
  a_pd_entry: assert property ($rose(power_down_o) |-> $past(!cke_i) && $past(cke_i, 2))
    else $error("power-down without clock enable fall");
  a_self_entry: assert property ($rose(self_refresh_o) |-> $past(ref_w && !cke_i) && $past(cke_i, 2))
    else $error("self refresh without entry command");
  a_self_exit: assert property ($fell(self_refresh_o) |-> $past(cke_i))
    else $error("self refresh left with clock enable low");
endmodule : sdram_cmd_properties

bind sdram_command_decode_bank_fsm sdram_cmd_properties u_props (.clk_i, .sys_rst_i, .cke_i, .cs_n_i, .ras_n_i,
  .cas_n_i, .we_n_i, .ba_i, .addr_i, .odt_i, .mode_load_o, .mode_sel_o, .mode_data_o, .refresh_o, .bank_idle_o,
  .bank_open_o, .power_down_o, .self_refresh_o, .odt_enable_o, .illegal_o);
`default_nettype wire

//--- tb/ctrl_model.sv
// Controller model: drives one command per clock on the command bus.
// Assumes its tasks are called from a single bench process.
`timescale 1ns/1ps
`default_nettype none
module ctrl_model (
  // Clock
  input wire logic clk_i,
  // Command bus
  output logic cke_o,
  output logic cs_n_o,
  output logic ras_n_o,
  output logic cas_n_o,
  output logic we_n_o,
  output logic [2:0] ba_o,
  output logic [13:0] addr_o,
  output logic odt_o
);
  initial
  begin
    {cke_o, cs_n_o, ras_n_o, cas_n_o, we_n_o} = 5'h1f;
    ba_o = 3'h0;
    addr_o = 14'h0000;
    odt_o = 1'b0;
  end

  // Strobes as {cs, ras, cas, we}; always a defined level
  task automatic cmd(input logic cke, input logic [3:0] s, input logic [2:0] b, input logic [13:0] a);
    @(posedge clk_i);
    #1;
    cke_o = cke;
    {cs_n_o, ras_n_o, cas_n_o, we_n_o} = s;
    ba_o = b;
    addr_o = a;
  endtask : cmd

  // Don't-care lines flip so a stale latch cannot pass
  task automatic nop(input logic cke, input int n);
    repeat (n) cmd(cke, 4'h7, ~ba_o, ~addr_o);
  endtask : nop
endmodule : ctrl_model
`default_nettype wire

//--- tb/test_sdram_command_decode_bank_fsm.sv
// Bench: directed scenarios for the command decoder and bank machines.
// Assumes the controller model and the bound checker are compiled first.
`timescale 1ns/1ps
`default_nettype none
module test_sdram_command_decode_bank_fsm;
  logic clk_i = 1'b0;
  logic sys_rst_i = 1'b1;
  logic cke, cs_n, ras_n, cas_n, we_n, odt;
  logic [2:0] ba, msel;
  logic [13:0] addr, mdata, row, col;
  logic mload, refr, pdn, sref, odt_en, illegal, seen;
  logic [7:0] idle, open;
  int num_errors = 0;
  int n_checks = 0;

  always #20 clk_i = ~clk_i;

  ctrl_model ctrl (.clk_i(clk_i), .cke_o(cke), .cs_n_o(cs_n), .ras_n_o(ras_n), .cas_n_o(cas_n), .we_n_o(we_n),
    .ba_o(ba), .addr_o(addr), .odt_o(odt));
  sdram_command_decode_bank_fsm dut (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .cke_i(cke), .cs_n_i(cs_n),
    .ras_n_i(ras_n), .cas_n_i(cas_n), .we_n_i(we_n), .ba_i(ba), .addr_i(addr), .odt_i(odt), .mode_load_o(mload),
    .mode_sel_o(msel), .mode_data_o(mdata), .row_o(row), .col_o(col), .refresh_o(refr), .bank_idle_o(idle),
    .bank_open_o(open), .power_down_o(pdn), .self_refresh_o(sref), .odt_enable_o(odt_en), .illegal_o(illegal));

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp)
    begin
      num_errors++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task automatic report_and_stop();
    $display("checks=%0d errors=%0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : report_and_stop

  // Cycles from the command edge until the bank reads idle
  task automatic idle_after(input logic [2:0] b, input int exp);
    int n;
    n = 0;
    do
    begin
      ctrl.nop(1'b1, 1);
      n++;
    end
    while (idle[b] !== 1'b1 && n < 12);
    chk(n, exp);
  endtask : idle_after

  task automatic t_mode();
    chk({idle, open, mload, refr, pdn, sref}, {8'hff, 12'h000});
    ctrl.cmd(1'b1, 4'h0, 3'h2, 14'h0a5c);
    ctrl.nop(1'b1, 1);
    chk({mload, msel, mdata}, {1'b1, 3'h2, 14'h0a5c});
    ctrl.nop(1'b1, 3);
  endtask : t_mode

  task automatic t_open_read_pre();
    ctrl.cmd(1'b1, 4'h3, 3'h5, 14'h1234);
    ctrl.nop(1'b1, 1);
    chk({idle[5], open[5], row}, {2'b00, 14'h1234});
    ctrl.nop(1'b1, 1);
    chk(open[5], 1'b1);
    ctrl.cmd(1'b1, 4'h5, 3'h5, 14'h0013);
    ctrl.cmd(1'b1, 4'h5, 3'h5, 14'h0021);
    ctrl.nop(1'b1, 1);
    chk({open[5], col}, {1'b1, 14'h0021});
    ctrl.nop(1'b1, 2);
    ctrl.cmd(1'b1, 4'h4, 3'h5, 14'h0007);
    ctrl.cmd(1'b1, 4'h2, 3'h5, 14'h0000);
    idle_after(3'h5, 1 + int'(cmd_decode_pkg::RP_CYC));
  endtask : t_open_read_pre

  task automatic t_auto_pre();
    for (int i = 0; i < 2; i++)
    begin
      ctrl.cmd(1'b1, 4'h3, 3'h1, 14'h0100);
      ctrl.nop(1'b1, 1);
      ctrl.cmd(1'b1, i ? 4'h4 : 4'h5, 3'h1, 14'h0409);
      idle_after(3'h1, 1 + int'(cmd_decode_pkg::BURST_CYC) + int'(cmd_decode_pkg::RP_CYC)
        + (i ? int'(cmd_decode_pkg::WR_CYC) : 0));
      chk(col, 14'h0009);
    end
  endtask : t_auto_pre

  task automatic t_pre_all();
    ctrl.cmd(1'b1, 4'h3, 3'h0, 14'h0001);
    ctrl.cmd(1'b1, 4'h3, 3'h7, 14'h0002);
    ctrl.nop(1'b1, 1);
    ctrl.cmd(1'b1, 4'h2, 3'h6, 14'h0000);
    ctrl.nop(1'b1, 2);
    chk({open[7], open[0], idle[6]}, 3'h7);
    ctrl.cmd(1'b1, 4'h2, 3'h3, 14'h0400);
    idle_after(3'h7, 2);
    chk(idle, 8'hff);
  endtask : t_pre_all

  task automatic t_illegal();
    ctrl.cmd(1'b1, 4'h5, 3'h4, 14'h0000);
    ctrl.nop(1'b1, 1);
    seen = illegal;
    ctrl.nop(1'b1, 1);
    chk({seen | illegal, idle[4]}, 2'b11);
    ctrl.cmd(1'b1, 4'h6, 3'h4, 14'h0000);
    ctrl.cmd(1'b1, 4'h8, 3'h4, 14'h0000);
    chk({illegal, idle[4]}, 2'b11);
    ctrl.cmd(1'b1, 4'h3, 3'h3, 14'h0055);
    chk(illegal, 1'b0);
    ctrl.cmd(1'b1, 4'h3, 3'h3, 14'h0066);
    ctrl.cmd(1'b1, 4'h1, 3'h0, 14'h0000);
    ctrl.nop(1'b1, 1);
    chk({refr, row, open[3]}, {1'b0, 14'h0055, 1'b1});
    ctrl.cmd(1'b1, 4'h2, 3'h3, 14'h0000);
    idle_after(3'h3, 2);
  endtask : t_illegal

  task automatic t_refresh_power();
    ctrl.cmd(1'b1, 4'h1, 3'h0, 14'h0000);
    ctrl.nop(1'b1, 1);
    chk({refr, idle}, {1'b1, 8'hff});
    ctrl.nop(1'b1, 5);
    ctrl.nop(1'b0, 2);
    chk(pdn, 1'b1);
    ctrl.cmd(1'b0, 4'h3, 3'h2, 14'h0000);
    ctrl.nop(1'b1, 3);
    chk({pdn, idle[2]}, 2'b01);
  endtask : t_refresh_power

  task automatic t_self();
    ctrl.odt_o = 1'b1;
    ctrl.cmd(1'b0, 4'h1, 3'h0, 14'h0000);
    ctrl.nop(1'b0, 2);
    chk({sref, odt_en}, 2'b10);
    ctrl.nop(1'b1, 1);
    ctrl.cmd(1'b1, 4'h3, 3'h0, 14'h0000);
    ctrl.nop(1'b1, 1);
    chk(idle[0], 1'b1);
    ctrl.nop(1'b1, 6);
    chk({sref, odt_en}, 2'b01);
    ctrl.odt_o = 1'b0;
  endtask : t_self

  initial
  begin
    repeat (5) @(posedge clk_i);
    #1;
    sys_rst_i = 1'b0;
    ctrl.nop(1'b1, 2);
    t_mode();
    t_open_read_pre();
    t_auto_pre();
    t_pre_all();
    t_illegal();
    t_refresh_power();
    t_self();
    report_and_stop();
  end

  // Whole run is about 85 cycles; far beyond that means a hang
  initial
  begin
    #(40 * 2000);
    num_errors++;
    report_and_stop();
  end
endmodule : test_sdram_command_decode_bank_fsm
`default_nettype wire
